// >>> common/pwr_clk_pkg.sv
`default_nettype none
package pwr_clk_pkg;

  // ----------------------------------------
  // register map (word index on the port)
  // ----------------------------------------
  localparam int ADDR_W = 2;
  localparam logic [1:0] OSC_MODE_IDX = 2'h0;
  localparam logic [1:0] TMR_CTRL_IDX = 2'h1;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // oscillator_mode_control fields
  // ----------------------------------------
  localparam int IDLE_BIT = 7;
  localparam int PRI_ACT_BIT = 3;
  localparam int INT_STB_BIT = 2;
  localparam int SEL_HI = 1;
  localparam int SEL_LO = 0;
  localparam logic [7:0] OSC_MODE_RST = 8'h00;

  // ----------------------------------------
  // secondary_timer_control fields
  // ----------------------------------------
  localparam int SEC_ACT_BIT = 6;
  localparam int SEC_EN_BIT = 3;

  // ----------------------------------------
  // clock select codes
  // ----------------------------------------
  localparam logic [1:0] SEL_PRI = 2'h0;
  localparam logic [1:0] SEL_SEC = 2'h1;
  localparam logic [1:0] SEL_RST = 2'h0;

  // ----------------------------------------
  // transition timing in source cycles, counter and sync widths
  // ----------------------------------------
  localparam int CNT_W = 3;
  localparam logic [2:0] OLD_CYCLES = 3'h2;
  localparam logic [2:0] NEW_CYCLES = 3'h3;
  localparam int SYNC_W = 7;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {src_pri, src_sec, src_int} src_e;
  typedef enum logic [1:0] {pm_run, pm_idle, pm_sleep} pm_e;

  // oscillator side levels, all asynchronous to mclk_in
  typedef struct packed {
    logic pri_tick;     // primary oscillator waveform
    logic sec_tick;     // timer oscillator waveform
    logic int_tick;     // internal block waveform
    logic pri_ready;    // primary oscillator has started
    logic sec_running;  // timer oscillator is oscillating
    logic int_stable;   // fast internal oscillator stable
    logic pri_is_int;   // primary_osc_config selects internal
  } osc_in_s;

  // clock gating controls toward the clock tree
  typedef struct packed {
    logic cpu_en;       // core clock gate
    logic periph_en;    // peripheral clock gate
    logic pri_osc_en;   // primary oscillator power
    src_e src;          // glitch-free mux select
  } clk_ctl_s;

endpackage
`default_nettype wire

// >>> src/sync2.sv
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic mclk_in,           // system clock
  input wire logic srst_in,           // sync reset, high
  input wire logic [W-1:0] async_in,  // foreign levels
  output logic [W-1:0] sync_out       // retimed levels
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // ----------------------------------------
  // two stages; only the second is read
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule
`default_nettype wire

// >>> src/tick_counter.sv
`default_nettype none
module tick_counter (
  input wire logic mclk_in,                       // system clock
  input wire logic srst_in,                       // sync reset, high
  input wire logic clear_in,                      // restart count
  input wire logic tick_in,                       // one source edge
  input wire logic [pwr_clk_pkg::CNT_W-1:0] target_in,  // edges needed
  output logic done_out                           // target reached
);

  logic [pwr_clk_pkg::CNT_W-1:0] cnt_ff;

  // ----------------------------------------
  // saturating edge count
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (srst_in || clear_in) begin
      cnt_ff <= '0;
    end else if (tick_in && !done_out) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign done_out = (cnt_ff >= target_in);

endmodule
`default_nettype wire

// >>> src/power_mode_clock_switch.sv
// Function
// - bit 7 decides peripheral clocking on halt, bits 1:0 choose the source.
// - select 00 primary, 01 timer oscillator, 1x internal block.
// - a new select starts a switch at once when that source runs.
// - halt stops all clocks, or only the cpu when idle bit set.
// - in run modes both core and peripheral clocks are on; here both stay off while a switch waits for the timer oscillator.
// - idle bit is sampled when each halt executes.
// - switch takes two old cycles then three new cycles.
// - bit 3 set while primary clock drives the device.
// - bit 2 set while fast internal oscillator stably drives device.
// - timer control bit 6 set while timer oscillator drives device.
// - no flag set means slow internal or fast not yet stable.
// - internal-as-primary may show both flags; internal mode clears bit 3.
// - reset enters primary run with primary flag set.
// - select 01 moves to timer oscillator, stops primary, swaps flags.
// - select 01 with timer oscillator disabled does not switch.
// - timer oscillator not yet running holds device clocks off.
// - returning to primary keeps timer clock until primary is ready.
// - return leaves idle and select bits alone, timer keeps running.
//
// The strobed register port and the placing of the registers were decided locally.
`default_nettype none
module power_mode_clock_switch (
  input wire logic mclk_in,                          // 250 MHz clock
  input wire logic srst_in,                          // sync reset, high
  input wire logic [pwr_clk_pkg::ADDR_W-1:0] addr_in, // register index
  input wire logic [pwr_clk_pkg::DATA_W-1:0] wdata_in, // write data
  input wire logic wr_in,                            // write strobe
  input wire logic rd_in,                            // read strobe
  output logic [pwr_clk_pkg::DATA_W-1:0] rdata_out,  // read data
  input wire logic halt_in,                          // power-down executed
  input wire logic wake_in,                          // wake event
  input wire pwr_clk_pkg::osc_in_s osc_in,           // oscillator levels
  output pwr_clk_pkg::clk_ctl_s clk_ctl_out          // clock gating
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  typedef enum logic [1:0] {
    sw_steady,
    sw_wait_ready,
    sw_old,
    sw_new
  } sw_state_e;

  sw_state_e sw_ff;
  sw_state_e nxt_sw;
  pwr_clk_pkg::src_e active_ff;
  pwr_clk_pkg::src_e target_ff;
  pwr_clk_pkg::src_e want_src;
  pwr_clk_pkg::pm_e pm_ff;
  logic idle_on_halt_ff;
  logic [1:0] clock_select_ff;
  logic secondary_osc_enable_ff;
  logic [pwr_clk_pkg::DATA_W-1:0] rdata_ff;
  pwr_clk_pkg::clk_ctl_s ctl_ff;
  pwr_clk_pkg::clk_ctl_s nxt_ctl;
  pwr_clk_pkg::osc_in_s osc_s;
  pwr_clk_pkg::osc_in_s osc_d_ff;
  logic pri_edge;
  logic sec_edge;
  logic int_edge;
  logic old_edge;
  logic new_edge;
  logic tgt_ready;
  logic cnt_clear;
  logic cnt_tick;
  logic [pwr_clk_pkg::CNT_W-1:0] cnt_target;
  logic cnt_done;
  logic hold_clocks;
  logic switch_req;
  logic primary_clock_active;
  logic internal_osc_stable;
  logic secondary_clock_active;
  logic [pwr_clk_pkg::DATA_W-1:0] osc_mode_rd;
  logic [pwr_clk_pkg::DATA_W-1:0] tmr_ctrl_rd;

  // ----------------------------------------
  // oscillator inputs come from other domains
  // ----------------------------------------
  sync2 #(
    .W(pwr_clk_pkg::SYNC_W)
  ) u_osc_sync (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .async_in(osc_in),
    .sync_out(osc_s)
  );

  // delayed copy of the retimed levels for edge finding
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      osc_d_ff <= '0;
    end else begin
      osc_d_ff <= osc_s;
    end
  end

  assign pri_edge = osc_s.pri_tick && !osc_d_ff.pri_tick;
  assign sec_edge = osc_s.sec_tick && !osc_d_ff.sec_tick;
  assign int_edge = osc_s.int_tick && !osc_d_ff.int_tick;

  // ----------------------------------------
  // source decode and readiness
  // ----------------------------------------
  // upper select bit alone picks the internal block
  function automatic pwr_clk_pkg::src_e decode_sel(input logic [1:0] sel);
    pwr_clk_pkg::src_e s;
    s = pwr_clk_pkg::src_int;
    if (sel == pwr_clk_pkg::SEL_PRI) begin
      s = pwr_clk_pkg::src_pri;
    end else if (sel == pwr_clk_pkg::SEL_SEC) begin
      s = pwr_clk_pkg::src_sec;
    end
    return s;
  endfunction

  function automatic logic pick_edge(input pwr_clk_pkg::src_e s, input logic p,
                                     input logic t, input logic i);
    logic e;
    e = i;
    if (s == pwr_clk_pkg::src_pri) begin
      e = p;
    end else if (s == pwr_clk_pkg::src_sec) begin
      e = t;
    end
    return e;
  endfunction

  assign want_src = decode_sel(clock_select_ff);
  assign old_edge = pick_edge(active_ff, pri_edge, sec_edge, int_edge);
  assign new_edge = pick_edge(target_ff, pri_edge, sec_edge, int_edge);

  // slow internal oscillator always runs, so internal is always ready
  always_comb begin
    unique case (target_ff)
      pwr_clk_pkg::src_pri: tgt_ready = osc_s.pri_ready;
      pwr_clk_pkg::src_sec: tgt_ready = osc_s.sec_running;
      default: tgt_ready = 1'b1;
    endcase
  end

  // a select of 01 with the timer oscillator off is not acted on
  assign switch_req = (want_src != active_ff) &&
                      ((want_src != pwr_clk_pkg::src_sec) ||
                       secondary_osc_enable_ff);

  // ----------------------------------------
  // switch sequencer
  // ----------------------------------------
  // a select change during a switch is honoured once it finishes
  always_comb begin
    nxt_sw = sw_ff;
    unique case (sw_ff)
      sw_steady: begin
        if (switch_req) begin
          nxt_sw = sw_wait_ready;
        end
      end
      sw_wait_ready: begin
        if (tgt_ready) begin
          nxt_sw = sw_old;
        end
      end
      sw_old: begin
        if (cnt_done) begin
          nxt_sw = sw_new;
        end
      end
      sw_new: begin
        if (cnt_done) begin
          nxt_sw = sw_steady;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sw_ff <= sw_steady;
    end else begin
      sw_ff <= nxt_sw;
    end
  end

  // the target is latched so a later write cannot redirect a switch
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      target_ff <= pwr_clk_pkg::src_pri;
    end else if (sw_ff == sw_steady && switch_req) begin
      target_ff <= want_src;
    end
  end

  // mux moves only after the new source's cycles are counted
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      active_ff <= pwr_clk_pkg::src_pri;
    end else if (sw_ff == sw_new && cnt_done) begin
      active_ff <= target_ff;
    end
  end

  // one counter serves both halves; cleared on each phase entry
  assign cnt_clear = (sw_ff != nxt_sw);
  assign cnt_tick = (sw_ff == sw_old) ? old_edge : new_edge;
  assign cnt_target = (sw_ff == sw_old) ? pwr_clk_pkg::OLD_CYCLES :
                      pwr_clk_pkg::NEW_CYCLES;

  tick_counter u_cnt (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .clear_in(cnt_clear),
    .tick_in(cnt_tick && (sw_ff == sw_old || sw_ff == sw_new)),
    .target_in(cnt_target),
    .done_out(cnt_done)
  );

  // ----------------------------------------
  // power mode
  // ----------------------------------------
  // idle bit is looked at only when the halt arrives
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pm_ff <= pwr_clk_pkg::pm_run;
    end else if (pm_ff == pwr_clk_pkg::pm_run && halt_in) begin
      pm_ff <= idle_on_halt_ff ? pwr_clk_pkg::pm_idle :
               pwr_clk_pkg::pm_sleep;
    end else if (pm_ff != pwr_clk_pkg::pm_run && wake_in) begin
      pm_ff <= pwr_clk_pkg::pm_run;
    end
  end

  // ----------------------------------------
  // clock gating
  // ----------------------------------------
  // a timer oscillator that has not started would give runt clocks
  assign hold_clocks = (sw_ff == sw_wait_ready) &&
                       (target_ff == pwr_clk_pkg::src_sec);

  always_comb begin
    nxt_ctl = '0;
    nxt_ctl.src = active_ff;
    nxt_ctl.cpu_en = (pm_ff == pwr_clk_pkg::pm_run) && !hold_clocks;
    nxt_ctl.periph_en = (pm_ff != pwr_clk_pkg::pm_sleep) && !hold_clocks;
    // outside sleep, primary stays powered while it is, or is about to be, the source
    nxt_ctl.pri_osc_en = (pm_ff != pwr_clk_pkg::pm_sleep) &&
                         (active_ff != pwr_clk_pkg::src_sec ||
                          target_ff == pwr_clk_pkg::src_pri);
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ctl_ff.cpu_en <= 1'b1;
      ctl_ff.periph_en <= 1'b1;
      ctl_ff.pri_osc_en <= 1'b1;
      ctl_ff.src <= pwr_clk_pkg::src_pri;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  assign clk_ctl_out = ctl_ff;

  // ----------------------------------------
  // status flags (derived, read only)
  // ----------------------------------------
  assign primary_clock_active = (active_ff == pwr_clk_pkg::src_pri);
  // internal-as-primary lets both flags stand; internal mode drops bit 3
  assign internal_osc_stable = osc_s.int_stable &&
                               ((active_ff == pwr_clk_pkg::src_int) ||
                                (primary_clock_active && osc_s.pri_is_int));
  assign secondary_clock_active = (active_ff == pwr_clk_pkg::src_sec);
  // slow internal or unstable fast internal leaves all three clear

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // a completed switch never touches these bits
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      idle_on_halt_ff <= pwr_clk_pkg::OSC_MODE_RST[pwr_clk_pkg::IDLE_BIT];
      clock_select_ff <= pwr_clk_pkg::SEL_RST;
    end else if (wr_in && addr_in == pwr_clk_pkg::OSC_MODE_IDX) begin
      idle_on_halt_ff <= wdata_in[pwr_clk_pkg::IDLE_BIT];
      clock_select_ff <= wdata_in[pwr_clk_pkg::SEL_HI:pwr_clk_pkg::SEL_LO];
    end
  end

  // timer oscillator is left running on the return to primary
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      secondary_osc_enable_ff <= 1'b0;
    end else if (wr_in && addr_in == pwr_clk_pkg::TMR_CTRL_IDX) begin
      secondary_osc_enable_ff <= wdata_in[pwr_clk_pkg::SEC_EN_BIT];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    osc_mode_rd = '0;
    osc_mode_rd[pwr_clk_pkg::IDLE_BIT] = idle_on_halt_ff;
    osc_mode_rd[pwr_clk_pkg::PRI_ACT_BIT] = primary_clock_active;
    osc_mode_rd[pwr_clk_pkg::INT_STB_BIT] = internal_osc_stable;
    osc_mode_rd[pwr_clk_pkg::SEL_HI:pwr_clk_pkg::SEL_LO] = clock_select_ff;
    tmr_ctrl_rd = '0;
    tmr_ctrl_rd[pwr_clk_pkg::SEC_ACT_BIT] = secondary_clock_active;
    tmr_ctrl_rd[pwr_clk_pkg::SEC_EN_BIT] = secondary_osc_enable_ff;
  end

  // data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk_in) begin
    if (srst_in || !rd_in) begin
      rdata_ff <= '0;
    end else if (addr_in == pwr_clk_pkg::OSC_MODE_IDX) begin
      rdata_ff <= osc_mode_rd;
    end else if (addr_in == pwr_clk_pkg::TMR_CTRL_IDX) begin
      rdata_ff <= tmr_ctrl_rd;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata_out = rdata_ff;

endmodule
`default_nettype wire

// >>> sim/power_mode_clock_switch_monitor.sv
`default_nettype none
module power_mode_clock_switch_monitor (
  input wire logic mclk_in,                                // system clock
  input wire logic srst_in,                                // sync reset
  input wire logic [pwr_clk_pkg::ADDR_W-1:0] addr_in,      // register index
  input wire logic [pwr_clk_pkg::DATA_W-1:0] wdata_in,     // write data
  input wire logic wr_in,                                  // write strobe
  input wire logic rd_in,                                  // read strobe
  input wire logic [pwr_clk_pkg::DATA_W-1:0] rdata_out,    // read data
  input wire logic halt_in,                                // power-down
  input wire logic wake_in,                                // wake event
  input wire pwr_clk_pkg::osc_in_s osc_in,                 // oscillator levels
  input wire pwr_clk_pkg::clk_ctl_s clk_ctl_out            // clock gating
);
  timeunit 1ns;
  timeprecision 100ps;
  logic idle_ff;
  logic sec_en_ff;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  // shadow of the idle and timer enable bits, so the halt and select checks know them
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      idle_ff <= 1'b0;
      sec_en_ff <= 1'b0;
    end else if (wr_in && addr_in == pwr_clk_pkg::OSC_MODE_IDX) begin
      idle_ff <= wdata_in[pwr_clk_pkg::IDLE_BIT];
    end else if (wr_in && addr_in == pwr_clk_pkg::TMR_CTRL_IDX) begin
      sec_en_ff <= wdata_in[pwr_clk_pkg::SEC_EN_BIT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reset_state: assert property (disable iff (1'b0) srst_in |=> clk_ctl_out.cpu_en && clk_ctl_out.periph_en
    && clk_ctl_out.pri_osc_en && clk_ctl_out.src == pwr_clk_pkg::src_pri) else $error("reset state wrong");
  a_run_both_on: assert property (clk_ctl_out.cpu_en |-> clk_ctl_out.periph_en)
    else $error("cpu clocked without peripherals");
  a_halt_to_idle: assert property (halt_in && idle_ff && clk_ctl_out.cpu_en
    |-> ##2 !clk_ctl_out.cpu_en && clk_ctl_out.periph_en) else $error("idle entry wrong");
  a_halt_to_sleep: assert property (halt_in && !idle_ff && clk_ctl_out.cpu_en
    |-> ##2 !clk_ctl_out.cpu_en && !clk_ctl_out.periph_en) else $error("sleep entry wrong");
  a_wake_to_run: assert property (wake_in && !clk_ctl_out.cpu_en && clk_ctl_out.periph_en
    |-> ##2 clk_ctl_out.cpu_en) else $error("wake from idle wrong");
  a_read_quiet: assert property ((!rd_in || addr_in[1]) |=> rdata_out == 8'h00)
    else $error("read data not zero");
  a_pri_flag: assert property (rd_in && addr_in == pwr_clk_pkg::OSC_MODE_IDX
    |=> rdata_out[pwr_clk_pkg::PRI_ACT_BIT] == (clk_ctl_out.src == pwr_clk_pkg::src_pri)) else $error("primary flag");
  a_sec_flag: assert property (rd_in && addr_in == pwr_clk_pkg::TMR_CTRL_IDX
    |=> rdata_out[pwr_clk_pkg::SEC_ACT_BIT] == (clk_ctl_out.src == pwr_clk_pkg::src_sec)) else $error("timer flag");
  a_sec_refused: assert property (wr_in && addr_in == pwr_clk_pkg::OSC_MODE_IDX && !sec_en_ff
    && wdata_in[1:0] == pwr_clk_pkg::SEL_SEC |=> (clk_ctl_out.src != pwr_clk_pkg::src_sec)[*8]) else $error("switch taken");
  a_src_holds: assert property ($changed(clk_ctl_out.src) |=> $stable(clk_ctl_out.src)[*8])
    else $error("source changed too soon");
  a_sec_stops_pri: assert property ($changed(clk_ctl_out.src) && clk_ctl_out.src == pwr_clk_pkg::src_sec
    |-> !clk_ctl_out.pri_osc_en) else $error("primary left powered");
endmodule
`default_nettype wire

// >>> sim/osc_model.sv
`default_nettype none
module osc_model (
  input wire logic mclk_in,                // system clock
  input wire logic pri_osc_en_in,          // primary oscillator power
  input wire logic secondary_run_mode_in,             // timer oscillator started
  input wire logic pri_int_in,             // primary configured as internal
  input wire logic int_stb_in,             // fast internal oscillator stable
  output pwr_clk_pkg::osc_in_s osc_out     // oscillator levels
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pri_t = 1'b0;
  logic sec_t = 1'b0;
  logic int_t = 1'b0;
  logic [4:0] start_ff = 5'h00;

  // free waveforms, periods unrelated to mclk; a stopped source holds low
  always #20 pri_t = pri_osc_en_in ? ~pri_t : 1'b0;
  always #28 sec_t = secondary_run_mode_in ? ~sec_t : 1'b0;
  always #24 int_t = ~int_t;

  // primary needs a start-up time after power-up, so the return path must wait
  always @(posedge mclk_in) begin
    if (!pri_osc_en_in) begin
      start_ff <= 5'h00;
    end else if (start_ff != 5'h1E) begin
      start_ff <= start_ff + 5'h01;
    end
  end

  assign osc_out = '{pri_t, sec_t, int_t, start_ff == 5'h1E, secondary_run_mode_in, int_stb_in, pri_int_in};
endmodule
`default_nettype wire

// >>> sim/test_power_mode_clock_switch.sv
`default_nettype none
module test_power_mode_clock_switch;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [pwr_clk_pkg::ADDR_W-1:0] addr_in = 2'h0;
  logic [pwr_clk_pkg::DATA_W-1:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic halt_in = 1'b0;
  logic wake_in = 1'b0;
  logic secondary_run_mode = 1'b0;
  logic pri_int = 1'b0;
  logic int_stb = 1'b1;
  logic [pwr_clk_pkg::DATA_W-1:0] rdata_out;
  pwr_clk_pkg::osc_in_s osc_in;
  pwr_clk_pkg::clk_ctl_s clk_ctl_out;
  int miscompares = 0;
  int checks = 0;

  always #2 mclk_in = ~mclk_in;

  power_mode_clock_switch power_mode_clock_switch_inst (.mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .halt_in(halt_in),
    .wake_in(wake_in), .osc_in(osc_in), .clk_ctl_out(clk_ctl_out));
  osc_model osc_model_inst (.mclk_in(mclk_in), .pri_osc_en_in(clk_ctl_out.pri_osc_en), .secondary_run_mode_in(secondary_run_mode),
    .pri_int_in(pri_int), .int_stb_in(int_stb), .osc_out(osc_in));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(exp, rdata_out);
  endtask

  // halt or wake pulse, then let the two-edge gating latency pass
  task automatic pulse(input logic h);
    @(posedge mclk_in);
    halt_in <= h;
    wake_in <= !h;
    @(posedge mclk_in);
    halt_in <= 1'b0;
    wake_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  task automatic gates(input logic [1:0] exp);
    chk({6'h00, exp}, {6'h00, clk_ctl_out.cpu_en, clk_ctl_out.periph_en});
  endtask

  // bounded wait; a switch is a handful of slow source edges plus sync delay
  task automatic wait_src(input logic [1:0] s);
    int n;
    n = 0;
    while (clk_ctl_out.src !== s && n < 400) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    chk({6'h00, s}, {6'h00, clk_ctl_out.src});
  endtask

  task automatic final_report;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk_in);
    srst_in <= 1'b0;
    repeat (40) @(posedge mclk_in);
    rd(2'h0, 8'h08);
    rd(2'h1, 8'h00);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h8C);
    rd(2'h0, 8'h88);
    pulse(1'b1);
    gates(2'h1);
    pulse(1'b0);
    gates(2'h3);
    wr(2'h0, 8'h00);
    pulse(1'b1);
    gates(2'h0);
    pulse(1'b0);
    gates(2'h3);
    wr(2'h0, 8'h01);
    repeat (60) @(posedge mclk_in);
    wait_src(2'h0);
    gates(2'h3);
    rd(2'h0, 8'h09);
    // enabling the timer oscillator before it runs must hold the clocks off
    wr(2'h1, 8'h08);
    repeat (30) @(posedge mclk_in);
    #1;
    gates(2'h0);
    secondary_run_mode <= 1'b1;
    wait_src(2'h1);
    chk(8'h00, {7'h00, clk_ctl_out.pri_osc_en});
    rd(2'h1, 8'h48);
    rd(2'h0, 8'h01);
    wr(2'h0, 8'h81);
    pulse(1'b1);
    gates(2'h1);
    pulse(1'b0);
    wr(2'h0, 8'h00);
    repeat (5) @(posedge mclk_in);
    #1;
    chk(8'h07, {5'h00, clk_ctl_out.cpu_en, clk_ctl_out.periph_en, clk_ctl_out.pri_osc_en});
    wait_src(2'h1);
    wait_src(2'h0);
    rd(2'h0, 8'h08);
    rd(2'h1, 8'h08);
    wr(2'h0, 8'h02);
    // two primary edges plus three internal edges cannot pass in 30 cycles
    repeat (30) @(posedge mclk_in);
    #1;
    chk(8'h00, {6'h00, clk_ctl_out.src});
    wait_src(2'h2);
    rd(2'h0, 8'h06);
    // fast internal oscillator losing stability leaves every source flag clear
    int_stb <= 1'b0;
    repeat (10) @(posedge mclk_in);
    rd(2'h0, 8'h02);
    rd(2'h1, 8'h08);
    int_stb <= 1'b1;
    wr(2'h0, 8'h03);
    repeat (60) @(posedge mclk_in);
    wait_src(2'h2);
    rd(2'h0, 8'h07);
    wr(2'h0, 8'h00);
    wait_src(2'h0);
    pri_int <= 1'b1;
    repeat (10) @(posedge mclk_in);
    rd(2'h0, 8'h0C);
    wr(2'h0, 8'h02);
    wait_src(2'h2);
    rd(2'h0, 8'h06);
    // second reset in mid-run, from internal clocking
    @(posedge mclk_in);
    srst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    repeat (40) @(posedge mclk_in);
    wait_src(2'h0);
    rd(2'h0, 8'h0C);
    rd(2'h1, 8'h00);
    final_report();
  end

  // watchdog, far beyond the several hundred cycles the scenarios need
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule

bind power_mode_clock_switch power_mode_clock_switch_monitor power_mode_clock_switch_monitor_inst (
  .mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .halt_in(halt_in), .wake_in(wake_in), .osc_in(osc_in), .clk_ctl_out(clk_ctl_out));
`default_nettype wire
